// ---- hw/cmp_ctrl_pkg.sv ----
// Constants for the dual comparator control block.
// Assumes one 100 MHz clock and an asynchronous active-low reset.
package cmp_ctrl_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned NUM_CMP = 2;
    // Settling window after enable, in microseconds
    localparam int unsigned SETTLE_US = 10;
    localparam int unsigned SETTLE_CYC = SETTLE_US * CLK_MHZ;
    localparam int unsigned SETTLE_W = 10;
    // Bit of the secondary power control word that cuts comparator power
    localparam int unsigned PWR_CMP_OFF_BIT = 5;
    localparam logic RST_OUT = 1'b1;
    localparam logic RST_FLAG = 1'b0;
    localparam logic RST_CFG = 1'b0;
    // Input select encodings
    localparam logic POS_SEL_A = 1'b0;
    localparam logic POS_SEL_B = 1'b1;
    localparam logic NEG_SEL_PIN = 1'b0;
    localparam logic NEG_SEL_REF = 1'b1;
    typedef enum logic [1:0] {
        PM_RUN,
        PM_IDLE,
        PM_PDOWN,
        PM_TOTAL_PDOWN
    } power_mode_t;
endpackage

// ---- hw/cmp_channel.sv ----
// One comparator channel: input select, output with disable forcing, change flag.
// Assumes the analog decisions arrive unsynchronised and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module cmp_channel
    import cmp_ctrl_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_active,
    input wire logic i_pos_sel,
    input wire logic i_neg_sel,
    input wire logic i_gt_a_pin,
    input wire logic i_gt_a_ref,
    input wire logic i_gt_b_pin,
    input wire logic i_gt_b_ref,
    input wire logic i_flag_clr,
    output logic o_out,
    output logic o_flag,
    output logic o_settling
);
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic out_r;
    logic out_nxt;
    logic flag_r;
    logic flag_nxt;
    logic [SETTLE_W-1:0] settle_r;
    logic [SETTLE_W-1:0] settle_nxt;
    logic active_d_r;
    logic settling_r;
    logic settling_nxt;
    logic sel;

    // ------------------------------------------------------------
    // Synchroniser and selection
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
        end
        else
        begin
            sync1_r <= {i_gt_b_ref, i_gt_b_pin, i_gt_a_ref, i_gt_a_pin};
            sync2_r <= sync1_r;
        end
    end

    // Select from the four pre-decided pairings
    always_comb
    begin
        sel = sync2_r[{i_pos_sel, i_neg_sel}];
    end

    // ------------------------------------------------------------
    // Output, flag and settle counter
    // ------------------------------------------------------------
    always_comb
    begin
        out_nxt = i_active ? sel : 1'b1;
        flag_nxt = flag_r;
        if (i_flag_clr)
        begin
            flag_nxt = 1'b0;
        end
        // Set wins over a simultaneous clear
        if (out_nxt != out_r)
        begin
            flag_nxt = 1'b1;
        end
        settle_nxt = settle_r;
        if (i_active && !active_d_r)
        begin
            settle_nxt = SETTLE_W'(SETTLE_CYC);
        end
        else if (!i_active)
        begin
            settle_nxt = '0;
        end
        else if (settle_r != '0)
        begin
            settle_nxt = settle_r - 1'b1;
        end
        // Registered so the advisory output comes straight from a flop
        settling_nxt = (settle_nxt != '0);
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            out_r <= RST_OUT;
            flag_r <= RST_FLAG;
            settle_r <= '0;
            active_d_r <= 1'b0;
            settling_r <= 1'b0;
        end
        else
        begin
            out_r <= out_nxt;
            flag_r <= flag_nxt;
            settle_r <= settle_nxt;
            active_d_r <= i_active;
            settling_r <= settling_nxt;
        end
    end

    assign o_out = out_r;
    assign o_flag = flag_r;
    assign o_settling = settling_r;

    property p_flag_set;
        @(posedge i_clk) disable iff (!i_rstn)
        (out_r != $past(out_r)) |-> flag_r;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("change flag missed an output change");

    property p_dis_high;
        @(posedge i_clk) disable iff (!i_rstn)
        !i_active |=> out_r;
    endproperty
    a_dis_high: assert property (p_dis_high)
        else $error("disabled comparator output not high");
endmodule // cmp_channel
`default_nettype wire

// ---- hw/dual_comparator_control.sv ----
// Dual comparator control: enables, input selects, pins, flags, interrupt, wake.
// Assumes analog comparator decisions on pins; software config as plain ports.
//
// What this block does
// - Output is one when positive input exceeds negative; readable and pin-drivable.
// - Positive input picks one of two pins; negative picks pin or reference.
// - Each comparator can request an interrupt on output change.
// - Change flag sets on every output change; poll or interrupt.
// - One shared interrupt; software reads both flags to find the source.
// - Disabled comparator forces output high; a rise sets the flag.
// - Comparators run in idle and power-down; total power-down disables them.
// - Enabled change interrupts in every mode and wakes the CPU in idle and power-down only.
// - Secondary power control bit 5 disables both comparators.
`timescale 1ns/1ps
`default_nettype none
module dual_comparator_control
    import cmp_ctrl_pkg::*;
#(
    parameter int unsigned N = NUM_CMP
)
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [N-1:0] i_enable,
    input wire logic [N-1:0] i_int_enable,
    input wire logic [N-1:0] i_pin_out_enable,
    input wire logic [N-1:0] i_pos_sel,
    input wire logic [N-1:0] i_neg_sel,
    input wire logic [N-1:0] i_flag_write,
    input wire logic [N-1:0] i_flag_wdata,
    input wire logic [7:0] i_secondary_power_control,
    input wire power_mode_t i_power_mode,
    input wire logic [N-1:0] i_gt_a_pin,
    input wire logic [N-1:0] i_gt_a_ref,
    input wire logic [N-1:0] i_gt_b_pin,
    input wire logic [N-1:0] i_gt_b_ref,
    output logic [N-1:0] o_comparator_output,
    output logic [N-1:0] o_comparator_change_flag,
    output logic [N-1:0] o_out_pin,
    output logic [N-1:0] o_out_pin_oe_n,
    output logic [N-1:0] o_settling,
    output logic o_irq,
    output logic o_wake
);
    logic [N-1:0] out_w;
    logic [N-1:0] flag_w;
    logic [N-1:0] settle_w;
    logic [N-1:0] active;
    logic [N-1:0] clr;
    logic cmp_off;
    logic irq_r;
    logic irq_nxt;
    logic wake_r;
    logic wake_nxt;
    logic [N-1:0] pin_r;
    logic [N-1:0] pin_nxt;
    logic [N-1:0] oe_n_r;
    logic [N-1:0] oe_n_nxt;
    logic [N-1:0] set_r;
    logic [N-1:0] set_nxt;

    // ------------------------------------------------------------
    // Power gating
    // ------------------------------------------------------------
    always_comb
    begin
        cmp_off = i_secondary_power_control[PWR_CMP_OFF_BIT];
        // Idle and power-down keep comparators alive
        active = (cmp_off || i_power_mode == PM_TOTAL_PDOWN) ? '0 : i_enable;
        // Only a zero written clears; writing one is ignored
        clr = i_flag_write & ~i_flag_wdata;
    end

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    for (genvar g = 0; g < N; g++)
    begin : g_ch
        cmp_channel u_ch (
            .i_clk(i_clk),
            .i_rstn(i_rstn),
            .i_active(active[g]),
            .i_pos_sel(i_pos_sel[g]),
            .i_neg_sel(i_neg_sel[g]),
            .i_gt_a_pin(i_gt_a_pin[g]),
            .i_gt_a_ref(i_gt_a_ref[g]),
            .i_gt_b_pin(i_gt_b_pin[g]),
            .i_gt_b_ref(i_gt_b_ref[g]),
            .i_flag_clr(clr[g]),
            .o_out(out_w[g]),
            .o_flag(flag_w[g]),
            .o_settling(settle_w[g])
        );
    end

    // ------------------------------------------------------------
    // Interrupt, wake and pin drive
    // ------------------------------------------------------------
    always_comb
    begin
        // One shared request for both flags
        irq_nxt = |(flag_w & i_int_enable);
        // Wake follows the request only while asleep; never in total power-down
        wake_nxt = (i_power_mode != PM_TOTAL_PDOWN) && (i_power_mode != PM_RUN)
            && irq_nxt;
        pin_nxt = out_w;
        oe_n_nxt = ~i_pin_out_enable;
        set_nxt = flag_w;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            irq_r <= 1'b0;
            wake_r <= 1'b0;
            pin_r <= '1;
            oe_n_r <= '1;
            set_r <= '0;
        end
        else
        begin
            irq_r <= irq_nxt;
            wake_r <= wake_nxt;
            pin_r <= pin_nxt;
            oe_n_r <= oe_n_nxt;
            set_r <= set_nxt;
        end
    end

    assign o_comparator_output = out_w;
    assign o_comparator_change_flag = flag_w;
    assign o_out_pin = pin_r;
    assign o_out_pin_oe_n = oe_n_r;
    assign o_settling = settle_w;
    assign o_irq = irq_r;
    assign o_wake = wake_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_irq;
        @(posedge i_clk) disable iff (!i_rstn)
        |(flag_w & i_int_enable) |=> o_irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq not raised for enabled flag");

    property p_irq_off;
        @(posedge i_clk) disable iff (!i_rstn)
        !(|(flag_w & i_int_enable)) |=> !o_irq;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("irq raised without enabled flag");

    property p_tpd;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_power_mode == PM_TOTAL_PDOWN) [*2] |=> o_comparator_output == '1;
    endproperty
    a_tpd: assert property (p_tpd)
        else $error("comparators not disabled in total power-down");

    property p_pcon;
        @(posedge i_clk) disable iff (!i_rstn)
        i_secondary_power_control[PWR_CMP_OFF_BIT] [*2] |=> o_comparator_output == '1;
    endproperty
    a_pcon: assert property (p_pcon)
        else $error("power control bit did not disable comparators");

    property p_wake;
        @(posedge i_clk) disable iff (!i_rstn)
        o_wake |-> $past(i_power_mode) != PM_TOTAL_PDOWN
            && $past(i_power_mode) != PM_RUN && o_irq;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake in total power-down");

    property p_hold;
        @(posedge i_clk) disable iff (!i_rstn)
        !(|(set_r & ~$past(clr) & ~flag_w));
    endproperty
    a_hold: assert property (p_hold)
        else $error("flag dropped without clear");

    property p_pin;
        @(posedge i_clk) disable iff (!i_rstn)
        1'b1 |=> o_out_pin == $past(out_w);
    endproperty
    a_pin: assert property (p_pin)
        else $error("pin does not follow output");

    sequence s_sleep_req;
        (i_power_mode == PM_IDLE || i_power_mode == PM_PDOWN) && |(flag_w & i_int_enable);
    endsequence
    property p_wake_on;
        @(posedge i_clk) disable iff (!i_rstn)
        s_sleep_req |=> o_wake;
    endproperty
    a_wake_on: assert property (p_wake_on)
        else $error("no wake for enabled change while asleep");

    property p_tpd_wake;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_power_mode == PM_TOTAL_PDOWN) |=> !o_wake;
    endproperty
    a_tpd_wake: assert property (p_tpd_wake)
        else $error("wake raised in total power-down");

    property p_oe;
        @(posedge i_clk) disable iff (!i_rstn)
        1'b1 |=> o_out_pin_oe_n == ~$past(i_pin_out_enable);
    endproperty
    a_oe: assert property (p_oe)
        else $error("pin enable does not follow request");

    property p_settle;
        @(posedge i_clk) disable iff (!i_rstn)
        $rose(active[0]) |=> o_settling[0];
    endproperty
    a_settle: assert property (p_settle)
        else $error("settling window not started on enable");
endmodule // dual_comparator_control
`default_nettype wire

// ---- sim/cmp_analog_model.sv ----
// Analog side model: turns pin voltage codes into comparator decisions.
// Assumes codes are held steady by the bench between changes.
`timescale 1ns/1ps
`default_nettype none
module cmp_analog_model
#(
    parameter logic [7:0] VREF_CODE = 8'h7b
)
(
    input wire logic [1:0][7:0] i_va,
    input wire logic [1:0][7:0] i_vb,
    input wire logic [1:0][7:0] i_vn,
    output logic [1:0] o_gt_a_pin,
    output logic [1:0] o_gt_a_ref,
    output logic [1:0] o_gt_b_pin,
    output logic [1:0] o_gt_b_ref
);
    always_comb
    begin
        for (int c = 0; c < 2; c++)
        begin
            o_gt_a_pin[c] = i_va[c] > i_vn[c];
            o_gt_a_ref[c] = i_va[c] > VREF_CODE;
            o_gt_b_pin[c] = i_vb[c] > i_vn[c];
            o_gt_b_ref[c] = i_vb[c] > VREF_CODE;
        end
    end
endmodule // cmp_analog_model
`default_nettype wire

// ---- sim/tb_dual_comparator_control.sv ----
// Self-checking bench for the dual comparator control block.
// Assumes the analog model answers combinationally.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_dual_comparator_control;
    import cmp_ctrl_pkg::*;
    localparam logic [7:0] VREF = 8'h7b;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [1:0] en = 2'h0, ien = 2'h0, pen = 2'h0, ps = 2'h0, ns = 2'h0;
    logic [1:0] fw = 2'h0, fd = 2'h0, prev, ex, fx;
    logic [7:0] pcon = 8'h0;
    power_mode_t pm = PM_RUN;
    logic [1:0][7:0] va = '0, vb = '0, vn = '0;
    logic [1:0] gap, gar, gbp, gbr, o_out, o_flag, o_pin, o_oe_n, o_set;
    logic o_irq, o_wake;
    int failures = 0, checked = 0, cyc = 0;
    integer seed = 32'h4726;
    always #5 i_clk = ~i_clk;
    cmp_analog_model #(.VREF_CODE(VREF)) i_cmp_analog_model (.i_va(va), .i_vb(vb),
        .i_vn(vn), .o_gt_a_pin(gap), .o_gt_a_ref(gar), .o_gt_b_pin(gbp), .o_gt_b_ref(gbr));
    dual_comparator_control i_dual_comparator_control (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_enable(en), .i_int_enable(ien), .i_pin_out_enable(pen), .i_pos_sel(ps),
        .i_neg_sel(ns), .i_flag_write(fw), .i_flag_wdata(fd),
        .i_secondary_power_control(pcon), .i_power_mode(pm), .i_gt_a_pin(gap),
        .i_gt_a_ref(gar), .i_gt_b_pin(gbp), .i_gt_b_ref(gbr),
        .o_comparator_output(o_out), .o_comparator_change_flag(o_flag), .o_out_pin(o_pin),
        .o_out_pin_oe_n(o_oe_n), .o_settling(o_set), .o_irq(o_irq), .o_wake(o_wake));
    function automatic logic gt(int c);
        return (ps[c] ? vb[c] : va[c]) > (ns[c] ? VREF : vn[c]);
    endfunction
    task automatic wt(int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic clr(logic [1:0] m, logic [1:0] d);
        @(negedge i_clk);
        fw = m;
        fd = d;
        @(negedge i_clk);
        fw = 2'h0;
    endtask
    task automatic rnd_v();
        for (int c = 0; c < 2; c++)
        begin
            va[c] = 8'($random(seed));
            vb[c] = 8'($random(seed));
            vn[c] = 8'($random(seed));
        end
    endtask
    task automatic end_of_test();
        if (failures == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Hang guard, far above the expected run length
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            failures++;
            end_of_test();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        wt(5);
        `CHK("out_rst", 2'h3, o_out)
        `CHK("flag_rst", 2'h0, o_flag)
        `CHK("irq_rst", 1'b0, o_irq)
        `CHK("oe_rst", 2'h3, o_oe_n)
        i_rstn = 1'b1;
        for (int k = 0; k < 40; k++)
        begin
            en = 2'h3;
            ien = 2'($random(seed));
            pen = 2'($random(seed));
            ps = 2'($random(seed));
            ns = 2'($random(seed));
            pm = power_mode_t'({$random(seed)} % 3);
            rnd_v();
            wt(6);
            clr(2'h3, 2'h0);
            wt(2);
            prev = o_out;
            rnd_v();
            wt(6);
            for (int c = 0; c < 2; c++)
            begin
                ex[c] = gt(c);
                fx[c] = ex[c] != prev[c];
            end
            `CHK("out", ex, o_out)
            `CHK("flag", fx, o_flag)
            `CHK("pin", ex | ~pen, o_pin | ~pen)
            `CHK("oe_n", ~pen, o_oe_n)
            `CHK("irq", |(fx & ien), o_irq)
            `CHK("wake", |(fx & ien) && pm != PM_RUN, o_wake)
        end
        // Disable by enable, power control bit and total power-down
        for (int w = 0; w < 3; w++)
        begin
            en = 2'h3;
            ps = 2'h0;
            ns = 2'h0;
            ien = 2'h3;
            pm = PM_IDLE;
            pcon = 8'h0;
            va = {8'h10, 8'h10};
            vn = {8'h80, 8'h80};
            wt(6);
            clr(2'h3, 2'h0);
            wt(2);
            `CHK("low", 2'h0, o_out)
            if (w == 0)
                en = 2'h0;
            else if (w == 1)
                pcon = 8'h01 << PWR_CMP_OFF_BIT;
            else
                pm = PM_TOTAL_PDOWN;
            wt(3);
            `CHK("forced", 2'h3, o_out)
            `CHK("fflag", 2'h3, o_flag)
            `CHK("fwake", w != 2, o_wake)
            `CHK("settle_off", 2'h0, o_set)
            clr(2'h3, 2'h3);
            wt(2);
            `CHK("w1", 2'h3, o_flag)
        end
        // Clear landing on the same edge as a change
        en = 2'h3;
        pm = PM_RUN;
        pcon = 8'h0;
        wt(6);
        clr(2'h3, 2'h0);
        wt(2);
        `CHK("settle_on", 2'h3, o_set)
        va = {8'hf0, 8'hf0};
        wt(2);
        fw = 2'h3;
        fd = 2'h0;
        wt(1);
        fw = 2'h0;
        wt(1);
        `CHK("race", 2'h3, o_flag)
        clr(2'h3, 2'h0);
        wt(1);
        `CHK("cleared", 2'h0, o_flag)
        wt(1000);
        `CHK("settle_end", 2'h0, o_set)
        // Interrupt off first, then comparator off, then flag cleared
        va = {8'h10, 8'h10};
        wt(6);
        clr(2'h3, 2'h0);
        ien = 2'h0;
        wt(2);
        `CHK("sleep_irq", 1'b0, o_irq)
        en = 2'h0;
        wt(3);
        `CHK("off_flag", 2'h3, o_flag)
        `CHK("off_irq", 1'b0, o_irq)
        clr(2'h3, 2'h0);
        wt(1);
        `CHK("off_clr", 2'h0, o_flag)
        // Reset in mid-run returns output, flag, irq, settling and pin to their idle values
        en = 2'h3;
        wt(6);
        i_rstn = 1'b0;
        wt(1);
        `CHK("mid_out", 2'h3, o_out)
        `CHK("mid_flag", 2'h0, o_flag)
        `CHK("mid_irq", 1'b0, o_irq)
        `CHK("mid_set", 2'h0, o_set)
        `CHK("mid_pin", 2'h3, o_pin)
        i_rstn = 1'b1;
        wt(6);
        `CHK("mid_low", 2'h0, o_out)
        end_of_test();
    end
endmodule // tb_dual_comparator_control
`default_nettype wire
